// >>> src/high_port_pkg.sv
/*
 * Holds the register map, reset values and control bit positions of the upper-port GPIO block.
 * Assumes an APB slave with 32-bit data and byte addresses.
 */
package high_port_pkg;
    // ==========================================================
    // Register offsets
    localparam logic [11:0] first_data_addr = 12'h00c8;
    localparam logic [11:0] second_data_addr = 12'h00d8;
    localparam logic [11:0] first_mode_addr = 12'h0100;
    localparam logic [11:0] second_mode_addr = 12'h0104;
    localparam logic [11:0] crossbar_config_two_addr = 12'h0108;
    localparam logic [11:0] external_memory_interface_ctrl_addr = 12'h010c;
    localparam logic [11:0] rmw_ctrl_addr = 12'h0110;
    // ==========================================================
    // Reset values and field positions
    localparam logic [7:0] data_reset = 8'h00ff;
    localparam logic [7:0] mode_reset = 8'h0000;
    localparam logic [7:0] config_reset = 8'h0000;
    localparam int pullup_global_disable_bit = 7;
    localparam int ext_mem_low_port_select_bit = 5;
    localparam int external_memory_interface_high_enable_bit = 0;
    localparam logic [23:0] upper_zero = 24'h0000_00;
    localparam int port_width = 8;
endpackage

// >>> src/pin_cell.sv
/*
 * Holds one port pin's driver and pullup logic.
 * Assumes the pin level is returned through the top module.
 */
`timescale 1ns/1ps
module pin_cell (
    input wire logic data_bit,
    input wire logic push_pull,
    input wire logic external_memory_interface_own,
    input wire logic external_memory_interface_bit,
    input wire logic external_memory_interface_read,
    input wire logic pullup_off,
    output logic drive_out,
    output logic drive_en,
    output logic pullup_en
);
    logic value;
    always_comb begin
        value = external_memory_interface_own ? external_memory_interface_bit : data_bit;
        drive_out = value;
        // Low is driven unless the memory interface is reading the pin, high only in push-pull mode.
        drive_en = (!value || push_pull) && !external_memory_interface_read;
        pullup_en = !pullup_off && !(drive_en && !value);
    end
endmodule

// >>> src/high_port_gpio_pullup.sv
/*
 * Holds the top of the upper-port GPIO block: APB registers, port latches and pin drivers.
 * Assumes pin inputs synchronous to clk and an external memory interface giving override data.
 */
// Chosen here: the APB register port.
`timescale 1ns/1ps
module high_port_gpio_pullup (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [15:0] pin_in,
    output logic [15:0] pin_out,
    output logic [15:0] pin_oe,
    output logic [15:0] pullup_en,
    input wire logic external_memory_interface_active,
    input wire logic external_memory_interface_read,
    input wire logic [15:0] external_memory_interface_mask,
    input wire logic [15:0] external_memory_interface_data_bus,
    input wire logic [15:0] external_memory_interface_out
);
    // ==========================================================
    // Register state
    // Latches, output modes and control bits, all eight bits wide except the one-bit rmw flag.
    logic [7:0] first_data;
    logic [7:0] second_data;
    logic [7:0] first_mode;
    logic [7:0] second_mode;
    logic [7:0] xbar;
    logic [7:0] external_memory_interface_ctrl;
    logic rmw;
    logic [7:0] next_first_data;
    logic [7:0] next_second_data;
    logic [7:0] next_first_mode;
    logic [7:0] next_second_mode;
    logic [7:0] next_xbar;
    logic [7:0] next_external_memory_interface_ctrl;
    logic next_rmw;

    // ==========================================================
    // Bus response state
    // Decoded read word and the flags of the access in progress.
    logic [31:0] read_value;
    logic mapped;
    logic access;
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;

    // ==========================================================
    // Pin state
    logic [15:0] all_data;
    logic [15:0] all_mode;
    logic [15:0] own_mask;
    logic [15:0] read_off_mask;
    logic pullup_off;
    logic external_memory_interface_on;
    logic [15:0] c_out;
    logic [15:0] c_oe;
    logic [15:0] c_pu;

    // ==========================================================
    // Register writes
    // A transfer is taken in its first access cycle only; pready then rises for one cycle,
    // so every access has exactly one wait state and no write can land twice.
    assign access = psel && penable && !pready;
    always_comb begin
        next_first_data = first_data;
        next_second_data = second_data;
        next_first_mode = first_mode;
        next_second_mode = second_mode;
        next_xbar = xbar;
        next_external_memory_interface_ctrl = external_memory_interface_ctrl;
        next_rmw = rmw;
        if (access && pwrite) begin
            if (paddr == high_port_pkg::first_data_addr) begin
                next_first_data = pwdata[7:0];
            end else if (paddr == high_port_pkg::second_data_addr) begin
                next_second_data = pwdata[7:0];
            end else if (paddr == high_port_pkg::first_mode_addr) begin
                next_first_mode = pwdata[7:0];
            end else if (paddr == high_port_pkg::second_mode_addr) begin
                next_second_mode = pwdata[7:0];
            end else if (paddr == high_port_pkg::crossbar_config_two_addr) begin
                // The low-port select bit is only stored; keeping it clear is up to software.
                next_xbar = pwdata[7:0];
            end else if (paddr == high_port_pkg::external_memory_interface_ctrl_addr) begin
                next_external_memory_interface_ctrl = pwdata[7:0];
            end else if (paddr == high_port_pkg::rmw_ctrl_addr) begin
                next_rmw = pwdata[0];
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            // Latches come up high, so every pin starts as an input with its pullup on.
            first_data <= high_port_pkg::data_reset;
            second_data <= high_port_pkg::data_reset;
            first_mode <= high_port_pkg::mode_reset;
            second_mode <= high_port_pkg::mode_reset;
            xbar <= high_port_pkg::config_reset;
            external_memory_interface_ctrl <= high_port_pkg::config_reset;
            rmw <= 1'b0;
        end else begin
            first_data <= next_first_data;
            second_data <= next_second_data;
            first_mode <= next_first_mode;
            second_mode <= next_second_mode;
            xbar <= next_xbar;
            external_memory_interface_ctrl <= next_external_memory_interface_ctrl;
            rmw <= next_rmw;
        end
    end

    // ==========================================================
    // Read mux
    // Unmapped offsets read as zero and are flagged as not mapped.
    always_comb begin
        read_value = 32'h0000_0000;
        mapped = 1'b1;
        if (paddr == high_port_pkg::first_data_addr) begin
            // Latch contents during a read-modify-write, pin levels otherwise.
            read_value = {high_port_pkg::upper_zero, rmw ? first_data : pin_in[7:0]};
        end else if (paddr == high_port_pkg::second_data_addr) begin
            read_value = {high_port_pkg::upper_zero, rmw ? second_data : pin_in[15:8]};
        end else if (paddr == high_port_pkg::first_mode_addr) begin
            read_value = {high_port_pkg::upper_zero, first_mode};
        end else if (paddr == high_port_pkg::second_mode_addr) begin
            read_value = {high_port_pkg::upper_zero, second_mode};
        end else if (paddr == high_port_pkg::crossbar_config_two_addr) begin
            read_value = {high_port_pkg::upper_zero, xbar};
        end else if (paddr == high_port_pkg::external_memory_interface_ctrl_addr) begin
            read_value = {high_port_pkg::upper_zero, external_memory_interface_ctrl};
        end else if (paddr == high_port_pkg::rmw_ctrl_addr) begin
            read_value = {31'h0000_0000, rmw};
        end else begin
            mapped = 1'b0;
        end
    end

    // ==========================================================
    // Bus response
    // Read data is loaded only by reads, so it stays put across writes.
    // The pready and pslverr outputs are one-cycle pulses.
    always_comb begin
        next_prdata = prdata;
        next_pready = access;
        next_pslverr = access && !mapped;
        if (access && !pwrite) begin
            next_prdata = read_value;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    // ==========================================================
    // Pin control
    // Both ports are flattened so that pin i of the cells is bit i of every vector.
    assign all_data = {second_data, first_data};
    assign all_mode = {second_mode, first_mode};
    // The memory interface only takes pins while it is mapped to the upper ports.
    assign external_memory_interface_on = external_memory_interface_ctrl[high_port_pkg::external_memory_interface_high_enable_bit] && external_memory_interface_active;
    assign own_mask = external_memory_interface_on ? external_memory_interface_mask : 16'h0000;
    // A read move releases only the data bus pins; the other pins keep their drivers.
    assign read_off_mask = (external_memory_interface_on && external_memory_interface_read) ? external_memory_interface_data_bus : 16'h0000;
    assign pullup_off = xbar[high_port_pkg::pullup_global_disable_bit];
    // One cell per pin; the cells hold no state of their own.
    for (genvar i = 0; i < 2 * high_port_pkg::port_width; i++) begin : g_pin
        pin_cell u_cell (
            .data_bit(all_data[i]),
            .push_pull(all_mode[i]),
            .external_memory_interface_own(own_mask[i]),
            .external_memory_interface_bit(external_memory_interface_out[i]),
            .external_memory_interface_read(read_off_mask[i]),
            .pullup_off(pullup_off),
            .drive_out(c_out[i]),
            .drive_en(c_oe[i]),
            .pullup_en(c_pu[i])
        );
    end

    // ==========================================================
    // Pin outputs
    // Every pin output comes from a flop, so pins follow a register or input one cycle later.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            // Open-drain with latches high: nothing is driven and every pullup is on.
            pin_out <= {high_port_pkg::data_reset, high_port_pkg::data_reset};
            pin_oe <= 16'h0000;
            pullup_en <= 16'hffff;
        end else begin
            pin_out <= c_out;
            pin_oe <= c_oe;
            pullup_en <= c_pu;
        end
    end
endmodule

// >>> test/high_port_gpio_pullup_monitor.sv
/* Assertion checker for the upper-port GPIO block.
   Assumes it is bound to the top module and sees only its ports. */
`timescale 1ns/1ps
module high_port_gpio_pullup_monitor (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic [15:0] pin_in,
    input wire logic [15:0] pin_out,
    input wire logic [15:0] pin_oe,
    input wire logic [15:0] pullup_en,
    input wire logic external_memory_interface_active,
    input wire logic external_memory_interface_read,
    input wire logic [15:0] external_memory_interface_mask,
    input wire logic [15:0] external_memory_interface_data_bus,
    input wire logic [15:0] external_memory_interface_out
);
    logic pud, next_pud, external_memory_interface_on, next_external_memory_interface_on;
    wire logic done_w = psel && penable && pready && pwrite;
    // Shadow copies of the pullup disable and memory interface enable bits.
    always_comb begin
        next_pud = pud;
        next_external_memory_interface_on = external_memory_interface_on;
        if (done_w && paddr == high_port_pkg::crossbar_config_two_addr) next_pud = pwdata[7];
        if (done_w && paddr == high_port_pkg::external_memory_interface_ctrl_addr) next_external_memory_interface_on = pwdata[0];
    end
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pud <= 1'b0;
            external_memory_interface_on <= 1'b0;
        end else begin
            pud <= next_pud;
            external_memory_interface_on <= next_external_memory_interface_on;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence taken_s;
        psel && penable && !pready;
    endsequence
    sequence pulse_s;
        pready ##1 !pready;
    endsequence
    ready_pulse_a: assert property (taken_s |=> pulse_s) else $error("bad ready pulse");
    error_reads_zero_a: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0000_0000)
        else $error("error read not zero");
    upper_bits_zero_a: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0000_00)
        else $error("upper read bits set");
    reset_state_a: assert property ($fell(sys_rst) |-> pin_oe == 16'h0000 && pullup_en == 16'hffff)
        else $error("bad pin state after reset");
    pullup_low_off_a: assert property ((pin_oe & ~pin_out & pullup_en) == 16'h0000)
        else $error("pullup on while driving low");
    global_disable_a: assert property (pud && $past(pud) |-> pullup_en == 16'h0000)
        else $error("pullup on while disabled");
    pullup_default_a: assert property (!pud && !$past(pud) |-> pullup_en == ~(pin_oe & ~pin_out))
        else $error("pullup off without cause");
    external_memory_interface_drive_a: assert property (external_memory_interface_on && external_memory_interface_active && !external_memory_interface_read |=>
        ((pin_out ^ $past(external_memory_interface_out)) & $past(external_memory_interface_mask)) == 16'h0000) else $error("external_memory_interface not driving");
    read_drivers_off_a: assert property (external_memory_interface_on && external_memory_interface_active && external_memory_interface_read |=>
        (pin_oe & $past(external_memory_interface_mask) & $past(external_memory_interface_data_bus)) == 16'h0000) else $error("bus driven");
endmodule
bind high_port_gpio_pullup high_port_gpio_pullup_monitor high_port_gpio_pullup_monitor_i (
    .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pready(pready), .pslverr(pslverr), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pullup_en(pullup_en),
    .external_memory_interface_active(external_memory_interface_active), .external_memory_interface_read(external_memory_interface_read), .external_memory_interface_mask(external_memory_interface_mask),
    .external_memory_interface_data_bus(external_memory_interface_data_bus), .external_memory_interface_out(external_memory_interface_out));

// >>> test/board_model.sv
/* Board-side model of the upper-port pins.
   Assumes the block's own drive wins over the bench on any pin that both drive. */
`timescale 1ns/1ps
module board_model (
    input wire logic clk,
    input wire logic [15:0] pin_out,
    input wire logic [15:0] pin_oe,
    input wire logic [15:0] pullup_en,
    input wire logic [15:0] ext_en,
    input wire logic [15:0] ext_val,
    output logic [15:0] pin_in
);
    logic [15:0] last;
    // A floating pin with no pullup shows the inverse of its last level.
    always_ff @(posedge clk) last <= pin_in;
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
        | (~pin_oe & ~ext_en & pullup_en) | (~pin_oe & ~ext_en & ~pullup_en & ~last);
endmodule

// >>> test/high_port_gpio_pullup_bench.sv
/* Self-checking bench for the upper-port GPIO block.
   Assumes the board model resolves every pin level. */
`timescale 1ns/1ps
module high_port_gpio_pullup_bench;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, external_memory_interface_active = 1'b0, external_memory_interface_read = 1'b0;
    logic [11:0] paddr = 12'h0000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic pready, pslverr, er;
    logic [15:0] pin_in, pin_out, pin_oe, pullup_en, external_memory_interface_mask = 16'h0000;
    logic [15:0] external_memory_interface_data_bus = 16'h0000, external_memory_interface_out = 16'h0000, ext_en = 16'h0000;
    logic [15:0] ext_val = 16'h00a5;
    int bad_count = 0;
    int samples_checked = 0;
    always #4 clk = ~clk;
    high_port_gpio_pullup high_port_gpio_pullup_i (.clk(clk), .sys_rst(sys_rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe(pin_oe), .pullup_en(pullup_en), .external_memory_interface_active(external_memory_interface_active),
        .external_memory_interface_read(external_memory_interface_read), .external_memory_interface_mask(external_memory_interface_mask), .external_memory_interface_data_bus(external_memory_interface_data_bus),
        .external_memory_interface_out(external_memory_interface_out));
    board_model board_model_i (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe),
        .pullup_en(pullup_en), .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));
    task automatic finish_test();
        if (bad_count == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        logic ok;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // Look between edges, where outputs show what the next rising edge samples.
        do begin
            @(negedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        ok = (pready === 1'b1);
        rd = prdata;
        er = pslverr;
        @(posedge clk);
        psel <= 1'b0;
        penable <= 1'b0;
        if (!ok) begin
            bad_count++;
            finish_test();
        end
    endtask
    initial begin
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        ext_en <= 16'h00ff;
        xfer(1'b0, high_port_pkg::first_data_addr, 32'h0000_0000);
        chk("first pins", 32'h0000_00a5, rd);
        xfer(1'b1, high_port_pkg::rmw_ctrl_addr, 32'h0000_0001);
        xfer(1'b0, high_port_pkg::second_data_addr, 32'h0000_0000);
        chk("second latch", 32'h0000_00ff, rd);
        xfer(1'b0, high_port_pkg::second_mode_addr, 32'h0000_0000);
        chk("second mode", 32'h0000_0000, rd);
        xfer(1'b1, high_port_pkg::first_mode_addr, 32'h0000_000f);
        xfer(1'b1, high_port_pkg::first_data_addr, 32'h0000_0033);
        ext_en <= 16'h0000;
        xfer(1'b0, high_port_pkg::first_data_addr, 32'h0000_0000);
        chk("first latch", 32'h0000_0033, rd);
        chk("first drive", 32'h0000_00cf, {24'h0000_00, pin_oe[7:0]});
        chk("first level", 32'h0000_0033, {24'h0000_00, pin_in[7:0]});
        chk("first pullup", 32'h0000_0033, {24'h0000_00, pullup_en[7:0]});
        xfer(1'b1, high_port_pkg::crossbar_config_two_addr, 32'h0000_0080);
        xfer(1'b0, high_port_pkg::crossbar_config_two_addr, 32'h0000_0000);
        chk("crossbar", 32'h0000_0080, rd);
        chk("pullups off", 32'h0000_0000, {16'h0000, pullup_en});
        xfer(1'b1, high_port_pkg::crossbar_config_two_addr, 32'h0000_0000);
        xfer(1'b0, 12'h0ff4, 32'h0000_0000);
        chk("unmapped data", 32'h0000_0000, rd);
        chk("unmapped error", 32'h0000_0001, {31'h0000_0000, er});
        xfer(1'b1, high_port_pkg::external_memory_interface_ctrl_addr, 32'h0000_0001);
        external_memory_interface_mask <= 16'hff00;
        external_memory_interface_data_bus <= 16'hff00;
        external_memory_interface_out <= 16'h5a00;
        external_memory_interface_active <= 1'b1;
        repeat (3) @(posedge clk);
        chk("external_memory_interface drive", 32'h0000_5a00, {16'h0000, pin_out & 16'hff00});
        chk("external_memory_interface enable", 32'h0000_a500, {16'h0000, pin_oe & 16'hff00});
        external_memory_interface_read <= 1'b1;
        repeat (3) @(posedge clk);
        chk("external_memory_interface read", 32'h0000_0000, {16'h0000, pin_oe & 16'hff00});
        finish_test();
    end
endmodule
